// File: core/tvr_defines.vh
// Subaddresses, field positions, reset values and timing constants of the teletext and blanking-interval registers.
`ifndef TVR_DEFINES_VH
`define TVR_DEFINES_VH

`define TVR_SUB_CW_CTRL0     5'h16
`define TVR_SUB_CW_DATA1     5'h17
`define TVR_SUB_CW_DATA2     5'h18
`define TVR_SUB_TTX_TIMING   5'h19

`define TVR_RST_CW_CTRL0     8'h00
`define TVR_RST_CW_DATA1     8'h00
`define TVR_RST_CW_DATA2     8'h00
`define TVR_RST_TTX_TIMING   8'h00

`define TVR_BIT_CRC_AUTO     4
`define TVR_BIT_ODD_EN       5
`define TVR_BIT_EVEN_EN      6
`define TVR_BIT_WSS_EN       7

`define TVR_CGMS_LINE_ODD    10'h014
`define TVR_CGMS_LINE_EVEN   10'h11b
`define TVR_WSS_LINE         10'h017

`define TVR_CGMS_SYMBOLS     5'h15
`define TVR_WSS_SYMBOLS      5'h0e
`define TVR_CRC_SEED         6'h3f
`define TVR_CRC_POLY         6'h03

`define TVR_TTX_BITS         360

`endif

// File: core/tvr_regs.v
// Teletext request strobe timing and copy-generation / wide-screen signalling registers with symbol FIFO.
`timescale 1ns/10ps
`include "tvr_defines.vh"

// Shift-register FIFO: the head entry and the flags are flip-flops.
module tvr_fifo #(
    parameter WIDTH = 2,
    parameter DEPTH = 4
) (
    // Clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // Fill side
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output reg              in_ready,
    // Drain side
    output reg              out_valid,
    output wire [WIDTH-1:0] out_data,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [7:0]       count_q;
    reg [7:0]       count_d;
    wire            push;
    wire            pop;
    integer         i;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem_q[0];

    always @* begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 8'h01;
        end else if (pop && !push) begin
            count_d = count_q - 8'h01;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            count_q   <= 8'h00;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {WIDTH{1'b0}};
            end
        end else begin
            count_q   <= count_d;
            in_ready  <= (count_d != DEPTH[7:0]);
            out_valid <= (count_d != 8'h00);
            for (i = 0; i < DEPTH; i = i + 1) begin
                if (pop && i < DEPTH - 1) begin
                    mem_q[i] <= mem_q[i+1];
                end
                if (push && i == (pop ? count_q - 8'h01 : count_q)) begin
                    mem_q[i] <= in_data;
                end
            end
        end
    end
endmodule

module tvr_regs #(
    parameter TTX_BITS   = `TVR_TTX_BITS,
    parameter FIFO_DEPTH = 4
) (
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // Host register access by subaddress
    input  wire       reg_wr_en,
    input  wire       reg_rd_en,
    input  wire [4:0] register_subaddress,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_q,
    // Video timing from the encoder's own timing generator
    input  wire       pal_mode,
    input  wire       field_start,
    input  wire       odd_field,
    input  wire       line_start,
    input  wire [9:0] line_number,
    input  wire       ttx_line,
    // Teletext request strobe to the teletext source
    output reg        teletext_request_strobe,
    // Blanking-interval symbols to the waveform generator
    output wire       vbi_sym_valid,
    output wire       vbi_sym_kind,
    output wire       vbi_sym_bit,
    input  wire       vbi_sym_ready,
    output reg        vbi_busy_q
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    reg  [7:0]  cw_ctrl0_q;
    reg  [7:0]  cw_data1_q;
    reg  [7:0]  cw_data2_q;
    reg  [7:0]  ttx_timing_q;
    reg  [7:0]  sh_ctrl0_q;
    reg  [19:0] sh_cgms_q;
    reg  [13:0] sh_wss_q;
    reg  [3:0]  sh_rise_q;
    reg  [3:0]  sh_fall_q;
    reg         sh_pal_q;
    reg  [9:0]  ttx_cnt_q;
    reg         ttx_run_q;
    reg         state_q;
    reg  [20:0] sym_shift_q;
    reg  [4:0]  sym_left_q;
    reg         sym_kind_q;
    wire [19:0] cgms_word;
    wire [5:0]  crc_bits;
    wire [9:0]  rise_pos;
    wire [9:0]  fall_pos;
    wire        fifo_in_ready;
    wire        cgms_line;
    wire        wss_line;
    wire [1:0]  fifo_out;

    // Six-bit CRC over the first fourteen copy word bits, bit 0 first.
    function [5:0] cgms_crc;
        input [13:0] data;
        reg   [5:0]  crc;
        reg          fb;
        integer      k;
        begin
            crc = `TVR_CRC_SEED;
            for (k = 0; k < 14; k = k + 1) begin
                fb  = crc[5] ^ data[k];
                crc = {crc[4:0], 1'b0} ^ (fb ? `TVR_CRC_POLY : 6'h00);
            end
            cgms_crc = crc;
        end
    endfunction

    // Register writes and reads.
    always @(posedge clk) begin
        if (sys_rst) begin
            cw_ctrl0_q   <= `TVR_RST_CW_CTRL0;
            cw_data1_q   <= `TVR_RST_CW_DATA1;
            cw_data2_q   <= `TVR_RST_CW_DATA2;
            ttx_timing_q <= `TVR_RST_TTX_TIMING;
            reg_rdata_q  <= 8'h00;
        end else begin
            if (reg_wr_en) begin
                case (register_subaddress)
                    `TVR_SUB_CW_CTRL0: begin
                        cw_ctrl0_q <= reg_wdata;
                    end
                    `TVR_SUB_CW_DATA1: begin
                        cw_data1_q <= reg_wdata;
                    end
                    `TVR_SUB_CW_DATA2: begin
                        cw_data2_q <= reg_wdata;
                    end
                    `TVR_SUB_TTX_TIMING: begin
                        ttx_timing_q <= reg_wdata;
                    end
                    default: begin
                    end
                endcase
            end
            if (reg_rd_en) begin
                case (register_subaddress)
                    `TVR_SUB_CW_CTRL0: begin
                        reg_rdata_q <= cw_ctrl0_q;
                    end
                    `TVR_SUB_CW_DATA1: begin
                        reg_rdata_q <= cw_data1_q;
                    end
                    `TVR_SUB_CW_DATA2: begin
                        reg_rdata_q <= cw_data2_q;
                    end
                    `TVR_SUB_TTX_TIMING: begin
                        reg_rdata_q <= ttx_timing_q;
                    end
                    default: begin
                        reg_rdata_q <= 8'h00;
                    end
                endcase
            end
        end
    end

    // Copy word: bits 0-7 from register two, 8-15 from one, 16-19 from zero.
    assign cgms_word = {cw_ctrl0_q[3:0], cw_data1_q, cw_data2_q};
    assign crc_bits  = cgms_crc(cgms_word[13:0]);

    // Shadow copies are loaded only at a field boundary.
    always @(posedge clk) begin
        if (sys_rst) begin
            sh_ctrl0_q <= 8'h00;
            sh_cgms_q  <= 20'h00000;
            sh_wss_q   <= 14'h0000;
            sh_rise_q  <= 4'h0;
            sh_fall_q  <= 4'h0;
            sh_pal_q   <= 1'b0;
        end else if (field_start) begin
            sh_ctrl0_q <= cw_ctrl0_q;
            sh_pal_q   <= pal_mode;
            sh_rise_q  <= ttx_timing_q[7:4];
            sh_fall_q  <= ttx_timing_q[3:0];
            if (cw_ctrl0_q[`TVR_BIT_CRC_AUTO]) begin
                sh_cgms_q <= {crc_bits, cgms_word[13:0]};
            end else begin
                sh_cgms_q <= cgms_word;
            end
            sh_wss_q <= {cw_data1_q[5:0], cw_data2_q};
        end
    end

    // Teletext request window, counted in pixel clocks from the line start.
    assign rise_pos = {6'h00, sh_rise_q};
    assign fall_pos = (sh_fall_q == 4'h0) ? rise_pos + TTX_BITS[9:0]
                                          : TTX_BITS[9:0] - {6'h00, sh_fall_q};

    always @(posedge clk) begin
        if (sys_rst) begin
            ttx_cnt_q               <= 10'h000;
            ttx_run_q               <= 1'b0;
            teletext_request_strobe <= 1'b0;
        end else begin
            if (line_start) begin
                ttx_cnt_q <= 10'h000;
                ttx_run_q <= ttx_line;
            end else if (ttx_cnt_q != 10'h3ff) begin
                ttx_cnt_q <= ttx_cnt_q + 10'h001;
            end
            teletext_request_strobe <= ttx_run_q && !line_start &&
                                       (ttx_cnt_q >= rise_pos) && (ttx_cnt_q < fall_pos);
        end
    end

    // Insertion lines for the copy word and wide-screen word.
    assign cgms_line = !sh_pal_q && ((odd_field && line_number == `TVR_CGMS_LINE_ODD &&
                                      sh_ctrl0_q[`TVR_BIT_ODD_EN]) ||
                                     (!odd_field && line_number == `TVR_CGMS_LINE_EVEN &&
                                      sh_ctrl0_q[`TVR_BIT_EVEN_EN]));
    assign wss_line  = sh_pal_q && odd_field && line_number == `TVR_WSS_LINE &&
                       sh_ctrl0_q[`TVR_BIT_WSS_EN];

    // Symbol serializer; it stalls while the FIFO is full.
    always @(posedge clk) begin
        if (sys_rst) begin
            state_q     <= ST_IDLE;
            sym_shift_q <= 21'h000000;
            sym_left_q  <= 5'h00;
            sym_kind_q  <= 1'b0;
            vbi_busy_q  <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (line_start && cgms_line) begin
                        sym_shift_q <= {sh_cgms_q, 1'b1};
                        sym_left_q  <= `TVR_CGMS_SYMBOLS;
                        sym_kind_q  <= 1'b1;
                        state_q     <= ST_RUN;
                        vbi_busy_q  <= 1'b1;
                    end else if (line_start && wss_line) begin
                        sym_shift_q <= {7'h00, sh_wss_q};
                        sym_left_q  <= `TVR_WSS_SYMBOLS;
                        sym_kind_q  <= 1'b0;
                        state_q     <= ST_RUN;
                        vbi_busy_q  <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (fifo_in_ready) begin
                        sym_shift_q <= {1'b0, sym_shift_q[20:1]};
                        sym_left_q  <= sym_left_q - 5'h01;
                        if (sym_left_q == 5'h01) begin
                            state_q    <= ST_IDLE;
                            vbi_busy_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    tvr_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (state_q == ST_RUN),
        .in_data   ({sym_kind_q, sym_shift_q[0]}),
        .in_ready  (fifo_in_ready),
        .out_valid (vbi_sym_valid),
        .out_data  (fifo_out),
        .out_ready (vbi_sym_ready)
    );

    assign vbi_sym_kind = fifo_out[1];
    assign vbi_sym_bit  = fifo_out[0];
endmodule

// File: verif/tvr_regs_properties.sv
// Concurrent checks on the ports of the teletext and blanking-interval register block.
`timescale 1ns/10ps
module tvr_regs_props (
    // Clock and reset
    input wire       clk,
    input wire       sys_rst,
    // Host access
    input wire       reg_rd_en,
    input wire [4:0] register_subaddress,
    input wire [7:0] reg_rdata_q,
    // Video timing
    input wire       line_start,
    input wire [9:0] line_number,
    input wire       ttx_line,
    // Outputs under check
    input wire       teletext_request_strobe,
    input wire       vbi_sym_valid,
    input wire       vbi_sym_kind,
    input wire       vbi_sym_bit,
    input wire       vbi_sym_ready,
    input wire       vbi_busy_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire vbi_line = line_start && (line_number == 10'h014 || line_number == 10'h11b || line_number == 10'h017);
    reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !teletext_request_strobe
        && !vbi_sym_valid && !vbi_busy_q && reg_rdata_q == 8'h00) else $error("Outputs not cleared by reset.");
    unmapped_read_a: assert property (reg_rd_en && (register_subaddress < 5'h16
        || register_subaddress > 5'h19) |=> reg_rdata_q == 8'h00) else $error("Unmapped read not zero.");
    strobe_line_low_a: assert property (line_start |=> !teletext_request_strobe)
        else $error("Strobe high at line start.");
    no_ttx_line_a: assert property (line_start && !ttx_line |=> !teletext_request_strobe [*8])
        else $error("Strobe on a line without teletext.");
    idle_stays_a: assert property (!vbi_busy_q && !vbi_line |=> !vbi_busy_q)
        else $error("Word started off its line.");
    word_start_a: assert property ($rose(vbi_busy_q) |-> $past(vbi_line))
        else $error("Word start without line.");
    first_symbol_a: assert property ($rose(vbi_busy_q) |-> ##2 vbi_sym_valid
        && (!vbi_sym_kind || vbi_sym_bit)) else $error("Reference symbol missing.");
    symbol_hold_a: assert property (vbi_sym_valid && !vbi_sym_ready |=> vbi_sym_valid
        && $stable(vbi_sym_kind) && $stable(vbi_sym_bit)) else $error("Head symbol changed while stalled.");
endmodule
bind tvr_regs tvr_regs_props u_props (
    .clk                     (clk),
    .sys_rst                 (sys_rst),
    .reg_rd_en               (reg_rd_en),
    .register_subaddress     (register_subaddress),
    .reg_rdata_q             (reg_rdata_q),
    .line_start              (line_start),
    .line_number             (line_number),
    .ttx_line                (ttx_line),
    .teletext_request_strobe (teletext_request_strobe),
    .vbi_sym_valid           (vbi_sym_valid),
    .vbi_sym_kind            (vbi_sym_kind),
    .vbi_sym_bit             (vbi_sym_bit),
    .vbi_sym_ready           (vbi_sym_ready),
    .vbi_busy_q              (vbi_busy_q)
);

// File: verif/tvr_ttx_source.sv
// Teletext source model: measures where the request window opens and how many bits it asks for.
`timescale 1ns/10ps
module tvr_ttx_source (
    // Clock and line timing
    input  wire       clk,
    input  wire       line_start,
    // Request from the block
    input  wire       teletext_request_strobe,
    // Measured window
    output reg  [9:0] rise_at_q,
    output reg  [9:0] bits_q
);
    reg [9:0] cnt_q = 10'h000;
    initial begin
        rise_at_q = 10'h3ff;
        bits_q = 10'h000;
    end
    always @(posedge clk) begin
        if (line_start) begin
            cnt_q <= 10'h001;
            bits_q <= 10'h000;
            rise_at_q <= 10'h3ff;
        end else begin
            cnt_q <= cnt_q + 10'h001;
            if (teletext_request_strobe) begin
                bits_q <= bits_q + 10'h001;
                if (bits_q == 10'h000) rise_at_q <= cnt_q;
            end
        end
    end
endmodule

// File: verif/tvr_regs_bench.sv
// Self-checking bench for the teletext strobe and blanking-interval register block.
`timescale 1ns/10ps
module tvr_regs_bench;
    localparam [9:0] TTX = 10'h028;
    reg        clk = 1'b0;
    reg        sys_rst = 1'b1;
    reg        reg_wr_en = 1'b0;
    reg        reg_rd_en = 1'b0;
    reg  [4:0] register_subaddress = 5'h00;
    reg  [7:0] reg_wdata = 8'h00;
    reg        pal_mode = 1'b0;
    reg        field_start = 1'b0;
    reg        odd_field = 1'b0;
    reg        line_start = 1'b0;
    reg  [9:0] line_number = 10'h000;
    reg        ttx_line = 1'b0;
    reg        vbi_sym_ready = 1'b0;
    wire [7:0] reg_rdata_q;
    wire       teletext_request_strobe, vbi_sym_valid, vbi_sym_kind, vbi_sym_bit, vbi_busy_q;
    wire [9:0] rise_at, bits;
    reg [20:0] sym, kinds;
    reg  [9:0] r, f;
    reg [39:0] tab = 40'h31_ff_25_f0_00;
    reg [31:0] vals = 32'ha5_5e_c3_2a;
    integer    failures = 0, n_checks = 0, cyc = 0, i;
    tvr_regs #(.TTX_BITS(TTX), .FIFO_DEPTH(4)) u_dut (
        .clk                     (clk),
        .sys_rst                 (sys_rst),
        .reg_wr_en               (reg_wr_en),
        .reg_rd_en               (reg_rd_en),
        .register_subaddress     (register_subaddress),
        .reg_wdata               (reg_wdata),
        .reg_rdata_q             (reg_rdata_q),
        .pal_mode                (pal_mode),
        .field_start             (field_start),
        .odd_field               (odd_field),
        .line_start              (line_start),
        .line_number             (line_number),
        .ttx_line                (ttx_line),
        .teletext_request_strobe (teletext_request_strobe),
        .vbi_sym_valid           (vbi_sym_valid),
        .vbi_sym_kind            (vbi_sym_kind),
        .vbi_sym_bit             (vbi_sym_bit),
        .vbi_sym_ready           (vbi_sym_ready),
        .vbi_busy_q              (vbi_busy_q)
    );
    tvr_ttx_source u_src (.clk(clk), .line_start(line_start), .teletext_request_strobe(teletext_request_strobe),
        .rise_at_q(rise_at), .bits_q(bits));
    initial forever #50 clk = ~clk;
    task chk(input [8*6-1:0] what, input [31:0] exp, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        begin
            @(posedge clk) {reg_wr_en, register_subaddress, reg_wdata} <= {1'b1, a, d};
            @(posedge clk) reg_wr_en <= 1'b0;
        end
    endtask
    task rd(input [4:0] a, input [7:0] e);
        begin
            @(posedge clk) {reg_rd_en, register_subaddress} <= {1'b1, a};
            @(posedge clk) reg_rd_en <= 1'b0;
            #1 chk("rdata", e, reg_rdata_q);
        end
    endtask
    task fld(input p, input o);
        begin
            @(posedge clk) {field_start, pal_mode, odd_field} <= {1'b1, p, o};
            @(posedge clk) field_start <= 1'b0;
        end
    endtask
    task line(input [9:0] n, input t);
        begin
            @(posedge clk) {line_start, line_number, ttx_line} <= {1'b1, n, t};
            @(posedge clk) line_start <= 1'b0;
        end
    endtask
    task run_ttx(input [7:0] w, input ld, input [9:0] er, input [9:0] eb);
        begin
            wr(5'h19, w);
            if (ld) fld(1'b0, 1'b1);
            line(10'h064, 1'b1);
            repeat (TTX + 24) @(posedge clk);
            chk("rise", er, rise_at);
            chk("bits", eb, bits);
        end
    endtask
    task get(input integer n);
        integer k, t;
        begin
            sym = 21'h0;
            kinds = 21'h0;
            for (k = 0; k < n; k = k + 1) begin
                t = 0;
                @(posedge clk);
                while (!(vbi_sym_valid === 1'b1 && vbi_sym_ready === 1'b1) && t < 200) begin
                    @(posedge clk);
                    t = t + 1;
                end
                sym[k] = vbi_sym_bit;
                kinds[k] = vbi_sym_kind;
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            $display("MISMATCH timeout expected done seen hang");
            test_done;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 4; i = i + 1) rd(5'h16 + i[4:0], 8'h00);
        for (i = 0; i < 4; i = i + 1) wr(5'h16 + i[4:0], vals[i*8 +: 8]);
        for (i = 0; i < 4; i = i + 1) rd(5'h16 + i[4:0], vals[i*8 +: 8]);
        wr(5'h1a, 8'hff);
        rd(5'h1a, 8'h00);
        $display("test registers done");
        for (i = 0; i < 5; i = i + 1) begin
            r = tab[i*8+4 +: 4];
            f = tab[i*8 +: 4];
            run_ttx(tab[i*8 +: 8], 1'b1, r + 10'h002, f != 0 ? TTX - f - r : TTX);
        end
        run_ttx(8'h70, 1'b0, 10'h005, TTX - 10'h004);
        $display("test strobe done");
        // The third pass has the CRC computed inside: x^6+x+1, seed all ones, over C0..C13 gives 13h.
        for (i = 0; i < 3; i = i + 1) begin
            wr(5'h16, (i == 1) ? 8'h4a : (i == 2) ? 8'h3a : 8'h2a);
            fld(1'b0, i != 1);
            line((i == 1) ? 10'h11b : 10'h014, 1'b0);
            repeat (10) @(posedge clk);
            chk("fill", 1, vbi_sym_valid);
            vbi_sym_ready <= 1'b1;
            get(21);
            vbi_sym_ready <= 1'b0;
            chk("cgms", (i == 2) ? {20'h4c35e, 1'b1} : {4'ha, 8'hc3, 8'h5e, 1'b1}, sym);
            chk("ckind", 21'h1fffff, kinds);
            repeat (4) @(posedge clk);
            chk("drain", 0, {vbi_busy_q, vbi_sym_valid});
        end
        $display("test copy word done");
        wr(5'h16, 8'h60);
        fld(1'b1, 1'b1);
        line(10'h014, 1'b0);
        repeat (5) @(posedge clk);
        chk("pal", 0, vbi_busy_q);
        wr(5'h16, 8'h80);
        fld(1'b1, 1'b1);
        vbi_sym_ready <= 1'b1;
        line(10'h017, 1'b0);
        get(14);
        chk("wss", {6'h03, 8'h5e}, sym[13:0]);
        chk("wkind", 0, kinds[13:0]);
        $display("test wide-screen done");
        test_done;
    end
endmodule
